// ===== tb/drs_mem_model.sv
// Purpose: Behavioural model of the 1024-bit dynamic memory device.
// Assumes: Strobes active high at the controller's pins.
// Notes: Output line toggles whenever it is not carrying sensed data.
module drs_mem_model
  import drs_pkg::*;
#(
  // Ones on a row left longer than this without a cycle decay to zero.
  parameter int RETAIN_NS = 2000000
) (
  // Strobes
  input wire logic prechargeStrobe,
  input wire logic cycleEnable,
  input wire logic writeStrobe,
  // Address and data
  input wire logic [ADDR_BITS-1:0] memAddr,
  input wire logic memDataIn,
  output logic memDataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cells [0:1023];
  logic [ADDR_BITS-1:0] addrLat;
  time lastRef [0:NUM_ROWS-1];
  initial begin
    memDataOut = 1'b0;
    foreach (cells[i]) cells[i] = 1'b0;
    foreach (lastRef[i]) lastRef[i] = 0;
  end
  // Column lines charged, so the output carries no data yet.
  // The address is taken a moment later, once the strobe's update settled.
  always @(posedge prechargeStrobe) begin
    #1;
    addrLat = memAddr;
    memDataOut = ~memDataOut;
    if ($time - lastRef[addrLat[ADDR_BITS-1:COL_BITS]] > RETAIN_NS) begin
      for (int c = 0; c < (1 << COL_BITS); c++) begin
        cells[{addrLat[ADDR_BITS-1:COL_BITS], COL_BITS'(c)}] = 1'b0;
      end
    end
  end
  // Precharge release rewrites the whole row, which restarts its leakage.
  always @(negedge prechargeStrobe) begin
    if (cycleEnable) begin
      memDataOut = cells[addrLat];
      lastRef[addrLat[ADDR_BITS-1:COL_BITS]] = $time;
    end
  end
  always @(negedge writeStrobe) begin
    if (cycleEnable) cells[addrLat] = memDataIn;
  end
  // Cells isolated: the pin no longer shows the last value.
  always @(negedge cycleEnable) memDataOut = ~memDataOut;
endmodule

// ===== tb/drs_sequencer_tb_top.sv
// Purpose: Self-checking bench of the memory cycle sequencer.
// Assumes: Short refresh slot so refreshes collide with requests.
// Notes: Inputs change on the falling clock edge only.
module drs_sequencer_tb_top;
  import drs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = 40;
  logic clock, rst, reqValid, reqWrite, reqData, reqReady, rdValid, rdData;
  logic prechargeStrobe, cycleEnable, writeStrobe, memDataIn, memDataOut;
  logic [ADDR_BITS-1:0] reqAddr, memAddr;
  int bad_count, tests_run, lat, ov;
  logic q, weLast;
  logic [ADDR_BITS-1:0] tab [0:4] = '{10'h000, 10'h3ff, 10'h01f, 10'h3e0,
    10'h21f};
  drs_sequencer #(.SLOT_CYC(SLOT), .OV_CYC(OV_MIN_CYC)) DUT (.clock(clock),
    .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .rdValid(rdValid),
    .rdData(rdData), .prechargeStrobe(prechargeStrobe),
    .cycleEnable(cycleEnable), .writeStrobe(writeStrobe), .memAddr(memAddr),
    .memDataIn(memDataIn), .memDataOut(memDataOut));
  drs_mem_model #(.RETAIN_NS(2 * NUM_ROWS * SLOT * 40)) mem (
    .prechargeStrobe(prechargeStrobe),
    .cycleEnable(cycleEnable), .writeStrobe(writeStrobe), .memAddr(memAddr),
    .memDataIn(memDataIn), .memDataOut(memDataOut));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One request; the caller sits at a falling edge.
  // A refresh keeps ready high, so ready falling marks our own take.
  task automatic access(input logic wr, input logic [ADDR_BITS-1:0] a,
    input logic d);
    int k;
    logic taken;
    k = 0;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    reqValid = 1'b1;
    do begin @(negedge clock); k++; end while (reqReady !== 1'b0 && k < 300);
    taken = (reqReady === 1'b0);
    reqValid = 1'b0;
    lat = 0;
    if (!wr) begin
      do begin @(negedge clock); lat++; end
      while (rdValid !== 1'b1 && lat < 300);
      q = rdData;
    end
    do begin @(negedge clock); k++; end while (reqReady !== 1'b1 && k < 600);
    if (!taken || k >= 600 || lat >= 300) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(negedge clock) begin
    if (writeStrobe) check(cycleEnable, 1'b1);
    if (weLast && !writeStrobe) check(cycleEnable, 1'b1);
    weLast = writeStrobe;
    if (prechargeStrobe && cycleEnable) ov++;
    else if (ov != 0) begin
      check(ov, OV_MIN_CYC);
      ov = 0;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check({prechargeStrobe, cycleEnable, writeStrobe}, 3'h0);
    check(reqReady, 1'b1);
  endtask
  task automatic t_edges();
    foreach (tab[i]) access(1'b1, tab[i], i[0]);
    foreach (tab[i]) begin
      access(1'b0, tab[i], 1'b0);
      check(q, i[0]);
    end
    // Two cycles beyond the intervals go to the data pin synchroniser.
    check(lat, PC_CYC + OV_MIN_CYC + PO_CYC + 2);
  endtask
  task automatic t_overwrite();
    access(1'b1, 10'h155, 1'b1);
    access(1'b0, 10'h155, 1'b0);
    check(q, 1'b1);
    access(1'b1, 10'h155, 1'b0);
    access(1'b0, 10'h155, 1'b0);
    check(q, 1'b0);
  endtask
  task automatic t_retain();
    access(1'b1, 10'h0a3, 1'b1);
    access(1'b1, 10'h0a4, 1'b0);
    // Longer than the model's retention, so only refresh keeps the one.
    repeat (3 * NUM_ROWS * SLOT) @(negedge clock);
    access(1'b0, 10'h0a3, 1'b0);
    check(q, 1'b1);
    access(1'b0, 10'h0a4, 1'b0);
    check(q, 1'b0);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst, reqValid, reqWrite, reqData, reqAddr} = '0;
    {bad_count, tests_run, ov} = '0;
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_edges();
    t_overwrite();
    t_retain();
    report_and_stop();
  end
endmodule

// ===== verilog/drs_pkg.sv
// Purpose: Constants and types for the dynamic memory cycle sequencer.
// Assumes: 25 MHz clock, one memory device with 5+5 address bits.
// Notes: Timing figures are parameters with plain defaults.
//
// Overview of operation
// R1: Read starts with precharge strobe falling first.
// R2: Device precharges column lines during precharge.
// R3: Address settles before access interval begins.
// R4: Device decodes addresses on precharge strobe.
// R5: Enable falls next, precharge still active.
// R6: Device reads selected row during overlap.
// R7: Precharge release triggers row refresh rewrite.
// R8: Access time is sum of intervals.
// R9: Every write begins with full read.
// R10: Write strobe after precharge-to-write interval.
// R11: Enable release isolates all cells.
// R12: Overlap held at least minimum time.
// R13: Overlap never exceeds maximum time.
// R14: Enable rises no earlier than write.
// R15: Write pulse never straddles enable release.
// R16: Every row refreshed within refresh period.
// R17: Array is 32 rows by 32 columns.
// R18: Address, data stable; cycles never overlap.
package drs_pkg;
  localparam int CLK_MHZ = 25;
  localparam int ROW_BITS = 5;
  localparam int COL_BITS = 5;
  localparam int ADDR_BITS = ROW_BITS + COL_BITS;
  localparam int NUM_ROWS = 32;
  // Interval figures in ns, refresh period in us; these are plain defaults, not part data.
  localparam int PC_NS = 80;
  localparam int OV_MIN_NS = 160;
  localparam int OV_MAX_NS = 400;
  localparam int PW_NS = 120;
  localparam int WE_NS = 80;
  localparam int PO_NS = 120;
  localparam int GAP_NS = 80;
  localparam int REFRESH_US = 2000;
  function automatic int ns_up(input int ns);
    return (ns * CLK_MHZ + 999) / 1000 < 1 ? 1 : (ns * CLK_MHZ + 999) / 1000;
  endfunction
  function automatic int ns_dn(input int ns);
    return (ns * CLK_MHZ) / 1000 < 1 ? 1 : (ns * CLK_MHZ) / 1000;
  endfunction
  localparam int PC_CYC = ns_up(PC_NS);
  localparam int OV_MIN_CYC = ns_up(OV_MIN_NS);
  localparam int OV_MAX_CYC = ns_dn(OV_MAX_NS);
  localparam int PW_CYC = ns_up(PW_NS);
  localparam int WE_CYC = ns_up(WE_NS);
  localparam int PO_CYC = ns_up(PO_NS);
  localparam int GAP_CYC = ns_up(GAP_NS);
  // Refresh spread over all rows, rounded down to stay inside the period.
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int ROW_REFRESH_CYC = REFRESH_CYC / NUM_ROWS;
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    DRS_IDLE, DRS_PRECHARGE_STROBE, DRS_OVER, DRS_HOLD, DRS_WRITE, DRS_GAP
  } drs_state_t;
endpackage

// ===== verilog/drs_refresh_timer.sv
// Purpose: Raises a refresh request once per row slot of the period.
// Assumes: Ack is a one-cycle pulse from the sequencer.
// Notes: A tick in the ack cycle is kept, the set wins.
module drs_refresh_timer
  import drs_pkg::*;
#(
  parameter int SLOT_CYC = ROW_REFRESH_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Request link
  drs_req_if.timer req
);
  initial begin
    if (SLOT_CYC < 2 || SLOT_CYC >= (1 << CNT_W)) begin
      $error("SLOT_CYC out of range");
    end
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic pend;
  } drs_tmr_t;
  drs_tmr_t st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (req.refAck) begin
      nxt_st.pend = 1'b0;
    end
    if (st_ff.cnt == CNT_W'(SLOT_CYC - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.pend = 1'b1; // see R16
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign req.refReq = st_ff.pend;
  pend_bound_a: assert property (@(posedge clock) disable iff (rst) // see R16
    (st_ff.cnt == CNT_W'(SLOT_CYC - 1)) |=> req.refReq)
    else $error("refresh tick lost");
endmodule

// ===== verilog/drs_req_if.sv
// Purpose: Request handshake between refresh timer and sequencer.
// Assumes: Single clock domain.
// Notes: The refresh request is a level held until acknowledged.
interface drs_req_if;
  logic refReq;
  logic refAck;
  modport timer (output refReq, input refAck);
  modport seq (input refReq, output refAck);
endinterface

// ===== verilog/drs_sequencer.sv
// Purpose: Drives the precharge, enable and write strobes of the memory.
// Assumes: Strobes active high here; board buffers invert as needed.
// Notes: Writes run as read-modify-write; refresh is a read, no result.
module drs_sequencer
  import drs_pkg::*;
#(
  parameter int SLOT_CYC = ROW_REFRESH_CYC,
  parameter int OV_CYC = OV_MIN_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // User request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_BITS-1:0] reqAddr,
  input wire logic reqData,
  output logic reqReady,
  output logic rdValid,
  output logic rdData,
  // Memory pins
  output logic prechargeStrobe,
  output logic cycleEnable,
  output logic writeStrobe,
  output logic [ADDR_BITS-1:0] memAddr,
  output logic memDataIn,
  input wire logic memDataOut
);
  initial begin
    if (OV_CYC < OV_MIN_CYC || OV_CYC > OV_MAX_CYC) begin
      $error("OV_CYC outside overlap limits");
    end
  end

  // ----------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------
  logic dSync1_ff, dSync2_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      dSync1_ff <= 1'b0;
      dSync2_ff <= 1'b0;
    end else begin
      dSync1_ff <= memDataOut;
      dSync2_ff <= dSync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------
  drs_req_if req ();
  drs_refresh_timer #(.SLOT_CYC(SLOT_CYC)) u_timer (
    .clock(clock),
    .rst(rst),
    .req(req)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef struct packed {
    drs_state_t state;
    logic [CNT_W-1:0] cnt;
    logic isWrite;
    logic isRefresh;
    logic [ROW_BITS-1:0] refRow;
    logic precharge_strobe;
    logic ce;
    logic we;
    logic [ADDR_BITS-1:0] addr;
    logic din;
    logic ready;
    logic rdValid;
    logic rdData;
    logic ack;
  } drs_seq_t;
  drs_seq_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdValid = 1'b0;
    nxt_st.ack = 1'b0;
    nxt_st.cnt = st_ff.cnt + 16'h0001;
    unique case (st_ff.state)
      DRS_IDLE: begin
        nxt_st.cnt = '0;
        // Refresh goes first so a busy user cannot starve retention.
        if (req.refReq) begin
          nxt_st.isRefresh = 1'b1;
          nxt_st.isWrite = 1'b0;
          nxt_st.addr = {st_ff.refRow, {COL_BITS{1'b0}}};
          nxt_st.refRow = st_ff.refRow + 5'h01; // see R16
          nxt_st.ack = 1'b1;
          nxt_st.precharge_strobe = 1'b1; // see R1
          // Ready stays high over a refresh, so a falling ready always
          // marks the take of a user request.
          nxt_st.state = DRS_PRECHARGE_STROBE;
        end else if (reqValid && st_ff.ready) begin
          nxt_st.isRefresh = 1'b0;
          nxt_st.isWrite = reqWrite; // see R9
          nxt_st.addr = reqAddr; // see R3
          nxt_st.din = reqData;
          nxt_st.precharge_strobe = 1'b1; // see R1
          nxt_st.ready = 1'b0;
          nxt_st.state = DRS_PRECHARGE_STROBE;
        end
      end
      DRS_PRECHARGE_STROBE: begin
        if (st_ff.cnt == CNT_W'(PC_CYC - 1)) begin
          nxt_st.ce = 1'b1; // see R5
          nxt_st.cnt = '0;
          nxt_st.state = DRS_OVER;
        end
      end
      DRS_OVER: begin
        // Overlap fixed between its minimum and maximum.
        if (st_ff.cnt == CNT_W'(OV_CYC - 1)) begin
          nxt_st.precharge_strobe = 1'b0; // see R12, R13
          nxt_st.cnt = '0;
          nxt_st.state = st_ff.isWrite ? DRS_WRITE : DRS_HOLD;
        end
      end
      DRS_HOLD: begin
        if (st_ff.cnt == CNT_W'(PO_CYC + 1)) begin
          nxt_st.ce = 1'b0;
          nxt_st.rdValid = !st_ff.isRefresh;
          nxt_st.rdData = dSync2_ff;
          nxt_st.cnt = '0;
          nxt_st.state = DRS_GAP;
        end
      end
      DRS_WRITE: begin
        // Write strobe rises after the interval, falls before enable.
        if (st_ff.cnt == CNT_W'(PW_CYC - 1)) begin
          nxt_st.we = 1'b1; // see R10
        end
        if (st_ff.cnt == CNT_W'(PW_CYC + WE_CYC - 1)) begin
          nxt_st.we = 1'b0; // see R14, R15
        end
        if (st_ff.cnt == CNT_W'(PW_CYC + WE_CYC)) begin
          nxt_st.ce = 1'b0; // see R14
          nxt_st.cnt = '0;
          nxt_st.state = DRS_GAP;
        end
      end
      DRS_GAP: begin
        if (st_ff.cnt == CNT_W'(GAP_CYC - 1)) begin
          nxt_st.ready = 1'b1; // see R18
          nxt_st.state = DRS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.state <= DRS_IDLE;
      st_ff.ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req.refAck = st_ff.ack;
  assign reqReady = st_ff.ready;
  assign rdValid = st_ff.rdValid;
  assign rdData = st_ff.rdData;
  assign prechargeStrobe = st_ff.precharge_strobe;
  assign cycleEnable = st_ff.ce;
  assign writeStrobe = st_ff.we;
  assign memAddr = st_ff.addr;
  assign memDataIn = st_ff.din;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence precOnly_s;
    prechargeStrobe && !cycleEnable;
  endsequence
  sequence overlap_s;
    prechargeStrobe && cycleEnable;
  endsequence
  precharge_strobe_first_a: assert property ( // see R1
    @(posedge clock) disable iff (rst)
    $rose(cycleEnable) |-> $past(prechargeStrobe))
    else $error("enable rose without precharge");
  // Precharge alone for exactly the enable delay, then the overlap.
  enable_during_precharge_strobe_a: assert property ( // see R5
    @(posedge clock) disable iff (rst)
    $rose(prechargeStrobe) |-> precOnly_s ##1 precOnly_s ##1 overlap_s)
    else $error("enable not within precharge");
  overlap_min_a: assert property ( // see R12
    @(posedge clock) disable iff (rst)
    $rose(cycleEnable) |-> overlap_s [*4])
    else $error("overlap too short");
  overlap_max_a: assert property ( // see R13
    @(posedge clock) disable iff (rst)
    $rose(cycleEnable) |-> ##[1:10] !prechargeStrobe)
    else $error("overlap too long");
  write_after_pw_a: assert property ( // see R10
    @(posedge clock) disable iff (rst)
    $rose(writeStrobe) |-> !$past(prechargeStrobe, 3))
    else $error("write strobe too early");
  we_before_ce_a: assert property ( // see R14, R15
    @(posedge clock) disable iff (rst)
    $fell(cycleEnable) |-> !writeStrobe && !$past(writeStrobe))
    else $error("write strobe straddles enable");
  write_needs_read_a: assert property ( // see R9
    @(posedge clock) disable iff (rst)
    writeStrobe |-> cycleEnable && !prechargeStrobe)
    else $error("write outside read frame");
  addr_stable_a: assert property ( // see R18
    @(posedge clock) disable iff (rst)
    (prechargeStrobe || cycleEnable) |=> $stable(memAddr) ||
      !(prechargeStrobe || cycleEnable))
    else $error("address moved in cycle");
endmodule
